// file: mpes_pkg.sv
// Package for the memory-controller performance event selector
package mpes_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_FRAME    = 8'h04;
  localparam logic [7:0] OFF_SCHED    = 8'h08;
  localparam logic [7:0] OFF_RETRY    = 8'h0C;
  localparam logic [7:0] OFF_PAGE     = 8'h10;
  localparam logic [7:0] OFF_THERMAL  = 8'h14;
  localparam logic [7:0] OFF_MAP      = 8'h18;
  localparam logic [7:0] OFF_COUNT    = 8'h1C;
  localparam logic [7:0] OFF_STATUS   = 8'h20;
  // Control register fields
  localparam int CTRL_CODE_LO = 0;
  localparam int CTRL_CODE_HI = 7;
  localparam int CTRL_EN      = 8;
  localparam int CTRL_CLEAR   = 9;
  localparam int CTRL_OCC_LO  = 19;
  localparam int CTRL_OCC_HI  = 21;
  localparam int CTRL_OCC_EN  = 7;
  localparam logic [2:0] OCC_SELECT = 3'h6;
  // Event codes
  localparam logic [7:0] EV_RETRY_MFULL   = 8'h02;
  localparam logic [7:0] EV_RETRY_STARVE  = 8'h03;
  localparam logic [7:0] EV_THERM_UP      = 8'h04;
  localparam logic [7:0] EV_THERM_DN      = 8'h05;
  localparam logic [7:0] EV_REFRESH       = 8'h06;
  localparam logic [7:0] EV_REFRESH_CONF  = 8'h07;
  localparam logic [7:0] EV_MODE_CHANGE   = 8'h08;
  localparam logic [7:0] EV_FRAME_KIND    = 8'h09;
  localparam logic [7:0] EV_RETRIES       = 8'h0B;
  localparam logic [7:0] EV_ADDR_PARITY   = 8'h0C;
  localparam logic [7:0] EV_FRAME_SLOT0   = 8'h0D;
  localparam logic [7:0] EV_FRAME_SLOT3   = 8'h10;
  localparam logic [7:0] EV_SCRUB         = 8'h11;
  localparam logic [7:0] EV_DISPATCHED    = 8'h12;
  localparam logic [7:0] EV_PAGE_MISS     = 8'h13;
  localparam logic [7:0] EV_PAGE_HIT      = 8'h14;
  localparam logic [7:0] EV_PAGE_EMPTY    = 8'h15;
  localparam logic [7:0] EV_PAGE_POLICY   = 8'h16;
  localparam logic [7:0] EV_MULTI_COLUMN  = 8'h17;
  localparam logic [7:0] EV_INDEX_RACE    = 8'h18;
  localparam logic [7:0] EV_THROTTLE_CONF = 8'h19;
  localparam logic [7:0] EV_SCHED_CMDS    = 8'h1C;
  localparam logic [7:0] EV_CTRL_CMDS     = 8'h1D;
  // Frame-event subconfig fields
  localparam int FRM_SLOT3_LO = 20;
  localparam int FRM_RSP_LO   = 8;
  localparam int FRM_CMD_LO   = 5;
  localparam logic [2:0] SLOT_CMD  = 3'h5;
  localparam logic [2:0] SLOT_RSP  = 3'h6;
  localparam logic [2:0] RSP_NONE  = 3'h6;
  // Frame kinds
  localparam logic [3:0] KIND_3CMD = 4'h0;
  localparam logic [3:0] KIND_WDAT = 4'h1;
  localparam logic [3:0] KIND_SYNC = 4'h2;
  localparam logic [3:0] KIND_CHNL = 4'h3;
  localparam logic [3:0] KIND_NOP  = 4'h8;
  localparam logic [3:0] KIND_1CMD = 4'hC;
  // Map, retry, page, thermal fields
  localparam int MAP_TYPE_LO    = 5;
  localparam logic [3:0] MAP_ALL = 4'h8;
  localparam int RETRY_FILT     = 7;
  localparam int RETRY_IDX_LO   = 1;
  localparam int MAP_IDX_LO     = 9;
  localparam int PAGE_DIR       = 0;
  localparam int THR_DN_LO      = 9;
  localparam int THR_UP_LO      = 7;
  localparam int THR_ANY        = 3;
  localparam int THR_MOD_LO     = 4;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// file: mpes_event_select.sv
// Event selection, qualification and counting with AXI4-Lite registers
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module mpes_event_select (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  frame_event,
  input  wire logic [1:0]  frame_cmd_kind,
  input  wire logic [7:0]  frame_rsp_kind,
  input  wire logic        link_frame_valid,
  input  wire logic [3:0]  link_frame_kind,
  input  wire logic        retry_seen,
  input  wire logic [5:0]  retry_index,
  input  wire logic        sched_badly_starved,
  input  wire logic        sched_starved,
  input  wire logic        scheduling_mode_transitions,
  input  wire logic        refresh_cmd,
  input  wire logic        refresh_conflict,
  input  wire logic        address_parity_error,
  input  wire logic        repeated_column_access,
  input  wire logic        page_empty,
  input  wire logic        page_hit,
  input  wire logic        page_miss,
  input  wire logic        scrub_transactions,
  input  wire logic        page_open_to_closed,
  input  wire logic        page_closed_to_open,
  input  wire logic        index_race,
  input  wire logic        accepted_controller_commands,
  input  wire logic        accepted_scheduler_commands,
  input  wire logic        dispatched_commands,
  input  wire logic        throttle_command_conflict,
  input  wire logic [3:0]  thermal_crossing_down,
  input  wire logic [3:0]  thermal_crossing_up,
  input  wire logic [2:0]  thermal_module,
  input  wire logic [8:0]  queue_entry_valid,
  input  wire logic [5:0]  queue_entry_index,
  output logic [31:0]      event_count,
  output logic             event_hit
);
  import mpes_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] frame_event_subconfig;
  logic [31:0] scheduler_subconfig;
  logic [31:0] retry_filter_subconfig;
  logic [31:0] page_policy_subconfig;
  logic [31:0] thermal_subconfig;
  logic [31:0] map_subconfig;
  logic        saw_overflow;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;
  logic        clear_req;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    unique case (aw_addr)
      OFF_CTRL, OFF_FRAME, OFF_SCHED, OFF_RETRY, OFF_PAGE, OFF_THERMAL, OFF_MAP,
      OFF_COUNT, OFF_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl                   <= 32'h0000_0000;
      frame_event_subconfig  <= 32'h0000_0000;
      scheduler_subconfig    <= 32'h0000_0000;
      retry_filter_subconfig <= 32'h0000_0000;
      page_policy_subconfig  <= 32'h0000_0000;
      thermal_subconfig      <= 32'h0000_0000;
      map_subconfig          <= 32'h0000_0000;
    end else if (wr_go) begin
      unique case (aw_addr)
        OFF_CTRL:    ctrl <= merge(ctrl, w_data, w_strb);
        OFF_FRAME:   frame_event_subconfig <= merge(frame_event_subconfig, w_data, w_strb);
        OFF_SCHED:   scheduler_subconfig <= merge(scheduler_subconfig, w_data, w_strb);
        OFF_RETRY:   retry_filter_subconfig <= merge(retry_filter_subconfig, w_data, w_strb);
        OFF_PAGE:    page_policy_subconfig <= merge(page_policy_subconfig, w_data, w_strb);
        OFF_THERMAL: thermal_subconfig <= merge(thermal_subconfig, w_data, w_strb);
        OFF_MAP:     map_subconfig <= merge(map_subconfig, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // Any write to the count word zeroes it
  assign clear_req = wr_go && (aw_addr == OFF_COUNT);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL:    s_axi_rdata <= ctrl;
        OFF_FRAME:   s_axi_rdata <= frame_event_subconfig;
        OFF_SCHED:   s_axi_rdata <= scheduler_subconfig;
        OFF_RETRY:   s_axi_rdata <= retry_filter_subconfig;
        OFF_PAGE:    s_axi_rdata <= page_policy_subconfig;
        OFF_THERMAL: s_axi_rdata <= thermal_subconfig;
        OFF_MAP:     s_axi_rdata <= map_subconfig;
        OFF_COUNT:   s_axi_rdata <= event_count;
        OFF_STATUS:  s_axi_rdata <= {30'h0000_0000, saw_overflow, event_hit};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification
  logic [7:0] code;
  logic [2:0] slot_sel;
  logic [2:0] rsp_sel;
  logic [2:0] cmd_sel;
  logic [3:0] kind_sel;
  logic [3:0] map_sel;
  logic       frame_slot_ev;
  logic       kind_ev;
  logic       retry_ev;
  logic       module_ok;
  logic       occ_mode;
  logic       occ_ev;
  logic       next_hit;

  assign code     = ctrl[CTRL_CODE_HI:CTRL_CODE_LO];
  assign slot_sel = frame_event_subconfig[FRM_SLOT3_LO +: 3];
  assign rsp_sel  = frame_event_subconfig[FRM_RSP_LO +: 3];
  assign cmd_sel  = frame_event_subconfig[FRM_CMD_LO +: 3];
  assign kind_sel = scheduler_subconfig[3:0];
  assign map_sel  = map_subconfig[MAP_TYPE_LO +: 4];
  assign occ_mode = (ctrl[CTRL_OCC_HI:CTRL_OCC_LO] == OCC_SELECT) && ctrl[CTRL_OCC_EN];

  always_comb begin
    frame_slot_ev = 1'b0;
    unique case (slot_sel)
      SLOT_CMD: begin
        // Only reads and writes exist; larger codes count nothing
        if (cmd_sel < 3'h2) begin
          frame_slot_ev = frame_cmd_kind[cmd_sel[0]];
        end
      end
      SLOT_RSP: begin
        frame_slot_ev = (rsp_sel != RSP_NONE) && frame_rsp_kind[rsp_sel];
      end
      default: frame_slot_ev = frame_event[slot_sel];
    endcase
  end

  always_comb begin
    unique case (kind_sel)
      KIND_3CMD, KIND_WDAT, KIND_SYNC, KIND_CHNL, KIND_NOP, KIND_1CMD:
        kind_ev = link_frame_valid && (link_frame_kind == kind_sel);
      default: kind_ev = 1'b0;
    endcase
  end

  assign retry_ev = retry_seen && (!retry_filter_subconfig[RETRY_FILT] ||
    (retry_index == retry_filter_subconfig[RETRY_IDX_LO +: 6]));

  assign module_ok = thermal_subconfig[THR_ANY] ||
    (thermal_module == thermal_subconfig[THR_MOD_LO +: 3]);

  // Occupancy: any valid entry matching index and type, all types at 8
  always_comb begin
    occ_ev = 1'b0;
    if (queue_entry_index == map_subconfig[MAP_IDX_LO +: 6]) begin
      if (map_sel == MAP_ALL) begin
        occ_ev = |queue_entry_valid;
      end else if (map_sel < MAP_ALL) begin
        occ_ev = queue_entry_valid[map_sel];
      end
    end
  end

  always_comb begin
    next_hit = 1'b0;
    if (occ_mode) begin
      next_hit = occ_ev;
    end else begin
      unique case (code)
        EV_RETRY_MFULL:   next_hit = retry_seen && sched_badly_starved;
        EV_RETRY_STARVE:  next_hit = retry_seen && sched_starved;
        EV_THERM_UP:      next_hit = module_ok &&
                                     thermal_crossing_up[thermal_subconfig[THR_UP_LO +: 2]];
        EV_THERM_DN:      next_hit = module_ok &&
                                     thermal_crossing_down[thermal_subconfig[THR_DN_LO +: 2]];
        EV_REFRESH:       next_hit = refresh_cmd;
        EV_REFRESH_CONF:  next_hit = refresh_conflict;
        EV_MODE_CHANGE:   next_hit = scheduling_mode_transitions;
        EV_FRAME_KIND:    next_hit = kind_ev;
        EV_RETRIES:       next_hit = retry_ev;
        EV_ADDR_PARITY:   next_hit = address_parity_error;
        EV_FRAME_SLOT3:   next_hit = frame_slot_ev;
        EV_SCRUB:         next_hit = scrub_transactions;
        EV_DISPATCHED:    next_hit = dispatched_commands;
        EV_PAGE_MISS:     next_hit = page_miss;
        EV_PAGE_HIT:      next_hit = page_hit;
        EV_PAGE_EMPTY:    next_hit = page_empty;
        EV_PAGE_POLICY:   next_hit = page_policy_subconfig[PAGE_DIR] ?
                                     page_open_to_closed : page_closed_to_open;
        EV_MULTI_COLUMN:  next_hit = repeated_column_access;
        EV_INDEX_RACE:    next_hit = index_race;
        EV_THROTTLE_CONF: next_hit = throttle_command_conflict;
        EV_SCHED_CMDS:    next_hit = accepted_scheduler_commands;
        EV_CTRL_CMDS:     next_hit = accepted_controller_commands;
        default:          next_hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: a single-bit increment keeps the step at one per cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_hit <= 1'b0;
    end else begin
      event_hit <= next_hit && ctrl[CTRL_EN];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_count  <= 32'h0000_0000;
      saw_overflow <= 1'b0;
    end else if (clear_req) begin
      event_count  <= 32'h0000_0000;
      saw_overflow <= 1'b0;
    end else if (event_hit) begin
      event_count <= event_count + 32'h0000_0001;
      if (&event_count) begin
        saw_overflow <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_step_one: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(clear_req) && !clear_req |-> event_count - $past(event_count) <= 32'h0000_0001)
    else $error("count stepped by more than one");
  a_count_follows: assert property (@(posedge clk_sys) disable iff (rst)
    event_hit && !clear_req |=> event_count == $past(event_count) + 32'h0000_0001)
    else $error("qualified event did not count");
  a_idle_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !event_hit && !clear_req |=> $stable(event_count))
    else $error("count moved without event");
  a_rsp_none: assert property (@(posedge clk_sys) disable iff (rst)
    code == EV_FRAME_SLOT3 && slot_sel == SLOT_RSP && rsp_sel == RSP_NONE && !occ_mode
    |=> !event_hit)
    else $error("empty response selection counted");
  a_bad_kind: assert property (@(posedge clk_sys) disable iff (rst)
    code == EV_FRAME_KIND && !occ_mode && kind_sel inside {4'h4, 4'h9, 4'hD} |=> !event_hit)
    else $error("illegal frame kind counted");
  a_hit_page: assert property (@(posedge clk_sys) disable iff (rst)
    code == EV_PAGE_HIT && !occ_mode && ctrl[CTRL_EN] && page_hit |=> event_hit)
    else $error("page hit not seen");
  a_retry_filter: assert property (@(posedge clk_sys) disable iff (rst)
    code == EV_RETRIES && !occ_mode && ctrl[CTRL_EN] && retry_seen
    && retry_filter_subconfig[RETRY_FILT]
    && retry_index != retry_filter_subconfig[RETRY_IDX_LO +: 6] |=> !event_hit)
    else $error("filtered retry counted");
  a_policy_dir: assert property (@(posedge clk_sys) disable iff (rst)
    code == EV_PAGE_POLICY && !occ_mode && ctrl[CTRL_EN] && page_open_to_closed
    && !page_closed_to_open |=> event_hit == $past(page_policy_subconfig[PAGE_DIR]))
    else $error("page policy direction wrong");
  a_bresp_back: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go |=> s_axi_bvalid)
    else $error("write response missing");
endmodule // mpes_event_select

// file: mpes_event_src.sv
// Far-side event source model for the event selector
`timescale 1ns/10ps
module mpes_event_src (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        fire,
  input  wire logic [4:0]  sel,
  input  wire logic [8:0]  val,
  input  wire logic [5:0]  idx,
  output logic [23:0]      hot,
  output logic [8:0]       vq,
  output logic [5:0]       iq
);
  ////////////////////////////////////////////////////////////////////////////
  // One source line raised per request, so one event per cycle at most
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hot <= 24'h000000;
      vq  <= 9'h000;
      iq  <= 6'h00;
    end else begin
      hot <= fire ? (24'h000001 << sel) : 24'h000000;
      vq  <= fire ? val : 9'h000;
      // Idle qualifier lines flip each cycle, so a stale index returns every second idle cycle
      iq  <= fire ? idx : ~iq;
    end
  end
endmodule // mpes_event_src

// file: tb_top.sv
// Self-checking testbench for the event selector
`timescale 1ns/10ps
module tb_top;
  import mpes_pkg::*;
  logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, fire;
  logic awready, wready, bvalid, arready, rvalid, hit;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, cnt, v;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  sel;
  logic [8:0]  val, vq;
  logic [5:0]  idx, iq;
  logic [23:0] hot;
  logic [3:0]  wstrb;
  int hits, h0;
  int error_cnt, samples_checked;
  mpes_event_src i_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .sel(sel), .val(val),
    .idx(idx), .hot(hot), .vq(vq), .iq(iq));
  mpes_event_select i_dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .frame_event(vq[7:0] & {8{hot[0]}}), .frame_cmd_kind(vq[1:0] & {2{hot[1]}}),
    .frame_rsp_kind(vq[7:0] & {8{hot[2]}}), .link_frame_valid(hot[3]),
    .link_frame_kind(iq[3:0]), .retry_seen(hot[4]), .retry_index(iq),
    .sched_badly_starved(hot[4] & vq[0]), .sched_starved(hot[4] & vq[1]),
    .scheduling_mode_transitions(hot[5]), .refresh_cmd(hot[6]), .refresh_conflict(hot[7]),
    .address_parity_error(hot[8]), .repeated_column_access(hot[9]), .page_empty(hot[10]),
    .page_hit(hot[11]), .page_miss(hot[12]), .scrub_transactions(hot[13]),
    .page_open_to_closed(hot[14]), .page_closed_to_open(hot[15]), .index_race(hot[16]),
    .accepted_controller_commands(hot[17]), .accepted_scheduler_commands(hot[18]),
    .dispatched_commands(hot[19]), .throttle_command_conflict(hot[20]),
    .thermal_crossing_down(vq[3:0] & {4{hot[21]}}),
    .thermal_crossing_up(vq[3:0] & {4{hot[22]}}), .thermal_module(iq[2:0]),
    .queue_entry_valid(vq & {9{hot[23]}}), .queue_entry_index(iq),
    .event_count(cnt), .event_hit(hit));
  // Counted pulses are held against the expected count as well
  always @(posedge clk_sys) begin
    if (rst === 1'b1)
      hits <= 0;
    else if (hit === 1'b1)
      hits <= hits + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t ns: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n);
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask
  // Subconfig first, then control, then clear so no stale count survives
  task automatic arm(input logic [7:0] o, input logic [31:0] d, input logic [31:0] c);
    axw(o, d);
    axw(OFF_CTRL, c);
    axw(OFF_COUNT, 32'h00000000);
    h0 = hits;
  endtask
  task automatic chkc(input logic [31:0] e);
    axr(OFF_COUNT);
    chk(v, e);
    chk(34'(hits - h0), e);
  endtask
  task automatic ev(input int s, input logic [8:0] d, input logic [5:0] x, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      fire <= 1'b1;
      sel <= 5'(s);
      val <= d;
      idx <= x;
    end
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  function automatic logic [8:0] qv(input int t);
    return 9'h100 | 9'(1 << t);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a <= 32; a += 4) begin
      axr(8'(a));
      chk({r, v}, 34'h0);
    end
    wstrb <= 4'h1;
    axw(OFF_RETRY, 32'hFFFFFFFF);
    wstrb <= 4'hF;
    axr(OFF_RETRY);
    chk({r, v}, 34'h0FF);
    axr(8'h24);
    chk({r, v}, {AXI_SLVERR, 32'h0});
    axw(8'h24, 32'hFFFFFFFF);
    chk(r, AXI_SLVERR);
    arm(OFF_PAGE, 32'h1, 32'h006);
    ev(6, 0, 0, 2);
    chkc(0);
    $display("test regs done");
  endtask
  task automatic t_simple();
    logic [7:0] cd [14] = '{8'h06, 8'h07, 8'h08, 8'h0C, 8'h17, 8'h15, 8'h14, 8'h13,
                            8'h11, 8'h18, 8'h1D, 8'h1C, 8'h12, 8'h19};
    int sl [14] = '{6, 7, 5, 8, 9, 10, 11, 12, 13, 16, 17, 18, 19, 20};
    for (int i = 0; i < 14; i++) begin
      arm(OFF_MAP, 0, 32'h100 | 32'(cd[i]));
      ev(sl[i], 0, 0, 3);
      ev(sl[i] == 20 ? 5 : sl[i] + 1, 0, 0, 1);
      chkc(3);
    end
    $display("test simple done");
  endtask
  task automatic t_frame();
    for (int k = 0; k < 8; k++) begin
      arm(OFF_FRAME, 32'(k) << 20, 32'h110);
      ev(0, 9'(1 << k), 0, 1);
      ev(0, 9'(~(1 << k)) & 9'h0FF, 0, 1);
      chkc((k == 5 || k == 6) ? 0 : 1);
    end
    for (int c = 0; c < 4; c++) begin
      arm(OFF_FRAME, 32'h00500000 | (32'(c) << 5), 32'h110);
      ev(1, 9'h001, 0, 1);
      ev(1, 9'h002, 0, 2);
      chkc(c == 0 ? 1 : (c == 1 ? 2 : 0));
    end
    for (int p = 0; p < 8; p++) begin
      arm(OFF_FRAME, 32'h00600000 | (32'(p) << 8), 32'h110);
      ev(2, 9'(1 << p), 0, 1);
      ev(2, 9'(~(1 << p)) & 9'h0FF, 0, 1);
      chkc(p == 6 ? 0 : 1);
    end
    for (int k = 0; k < 16; k++) begin
      arm(OFF_SCHED, 32'(k), 32'h109);
      ev(3, 0, 6'(k), 1);
      ev(3, 0, 6'(k ^ 1), 1);
      chkc((k < 4 || k == 8 || k == 12) ? 1 : 0);
    end
    $display("test frame done");
  endtask
  task automatic t_misc();
    arm(OFF_RETRY, 0, 32'h10B);
    ev(4, 0, 6'd5, 1);
    ev(4, 0, 6'd9, 2);
    chkc(3);
    arm(OFF_RETRY, 32'h92, 32'h10B);
    ev(4, 0, 6'd5, 1);
    ev(4, 0, 6'd9, 2);
    chkc(2);
    for (int m = 0; m < 2; m++) begin
      arm(OFF_RETRY, 0, 32'h102 + 32'(m));
      ev(4, 9'h001, 0, 1);
      ev(4, 9'h002, 0, 2);
      chkc(m == 0 ? 1 : 2);
      arm(OFF_PAGE, 32'(m), 32'h116);
      ev(14, 0, 0, 1);
      ev(15, 0, 0, 2);
      chkc(m == 1 ? 1 : 2);
    end
    $display("test misc done");
  endtask
  task automatic t_therm();
    for (int u = 0; u < 2; u++)
      for (int t = 0; t < 4; t++) begin
        int s;
        s = u ? 22 : 21;
        arm(OFF_THERMAL, (32'(t) << (u ? 7 : 9)) | 32'h8, u ? 32'h104 : 32'h105);
        ev(s, 9'(1 << t), 6'd2, 1);
        ev(s, 9'(~(1 << t)) & 9'h00F, 6'd2, 1);
        chkc(1);
        arm(OFF_THERMAL, (32'(t) << (u ? 7 : 9)) | 32'h50, u ? 32'h104 : 32'h105);
        ev(s, 9'(1 << t), 6'd5, 1);
        ev(s, 9'(1 << t), 6'd2, 1);
        chkc(1);
      end
    $display("test thermal done");
  endtask
  task automatic t_occ();
    for (int m = 0; m < 9; m++) begin
      arm(OFF_MAP, 32'h1800 | (32'(m) << 5), 32'h00300180);
      ev(23, qv(m == 8 ? 2 : m), 6'd12, 4);
      ev(23, qv(m == 8 ? 2 : m), 6'd13, 1);
      ev(23, qv((m + 1) % 8), 6'd12, 1);
      chkc(m == 8 ? 5 : 4);
    end
    $display("test occupancy done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, fire} = 7'h40;
    {awaddr, araddr, wdata, sel, val, idx} = '0;
    wstrb = 4'hF;
    {error_cnt, samples_checked} = '0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_simple();
    t_frame();
    t_misc();
    t_therm();
    t_occ();
    final_report();
  end
endmodule // tb_top
